// ===== include/pwsfsm_pkg.sv
// shared constants and state codes of the power, wake and sleep sequencer
package pwsfsm_pkg;
  // system clock period, 200 MHz
  localparam int CLK_PERIOD_PS = 5000;
  // counter width, wide enough for the longest settle and the refresh interval
  localparam int CNT_W = 20;
  // slow rc cycles of synchronisation after a hibernation wake
  localparam logic [CNT_W-1:0] SYNC_SLOW_CYC = 20'h00003;
  // low power rc cycles spent in the wake-up controller
  localparam logic [CNT_W-1:0] WAKE_CTRL_LP_CYC = 20'h00007;
  // low power rc cycles from timer interrupt to woken-up flag
  localparam logic [CNT_W-1:0] TIMER_WAKE_LP_CYC = 20'h00006;
  // 3.5 low power rc cycles, counted as seven half cycles
  localparam logic [CNT_W-1:0] SWITCH_LP_HALF = 20'h00007;
  // one refresh interval count is 64 slow rc cycles
  localparam int REFRESH_LSB_SHIFT = 6;
  // default width of the refresh interval field
  localparam int REFRESH_W = 8;
  // analog settle times in ns; chosen so the hibernation wake totals about 180 us
  localparam int BG_SETTLE_NS = 40000;
  localparam int LDO_SETTLE_NS = 46000;
  // rail ramp on a sleep wake; with 7 + 3.5 low power cycles the total is about 865 us
  localparam int RAIL_SETTLE_NS = 165000;
  // bandgap refresh and brown-out check windows inside the sleep loop
  localparam int REFRESH_SETTLE_NS = 10000;
  localparam int BOD_CHECK_NS = 1000;
  // least times round up to whole clock cycles
  localparam int BG_SETTLE_CYC = (BG_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LDO_SETTLE_CYC = (LDO_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAIL_SETTLE_CYC = (RAIL_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFRESH_SETTLE_CYC = (REFRESH_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BOD_CHECK_CYC = (BOD_CHECK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // sequencer states
  typedef enum logic [3:0] {
    ST_SYNC = 4'h0,
    ST_BG_ON = 4'h1,
    ST_LDO_ON = 4'h2,
    ST_RUN = 4'h3,
    ST_SLEEP = 4'h4,
    ST_REFRESH = 4'h5,
    ST_BOD_CHECK = 4'h6,
    ST_WAKE_CTRL = 4'h7,
    ST_TIMER_WAKE = 4'h8,
    ST_RAILS = 4'h9,
    ST_SWITCH = 4'ha,
    ST_HIBERNATE = 4'hb
  } pwsfsm_state_t;
endpackage : pwsfsm_pkg

// ===== src/pwsfsm_top.sv
// power-up, wake-up, go-to-sleep and bandgap refresh sequencer
`timescale 1ns/1ps
// How it works
// - hibernation exits only on designated wake pins
// - at least 3 slow rc cycles sync first
// - bandgap and fast clock, regulator, then reset release
// - hibernation wake totals about 180 us
// - gpio sleep wake totals about 865 us
// - retained ram runs application after a sleep wake, otherwise boot code
// - wake controller takes 7 low power cycles
// - clock switch takes 3.5 low power cycles
// - timer wake raises flag after 6 cycles
// - sleep gates blocks and holds reference voltages
// - refresh: bandgap on, refresh, brown-out check, resleep
// - refresh loop repeats in hardware until wake
// - refresh interval count equals 64 slow cycles
// - hibernation wakes only from five port pins
module pwsfsm_top #(
  parameter int REFRESH_W = pwsfsm_pkg::REFRESH_W,
  parameter int BG_SETTLE_CYC = pwsfsm_pkg::BG_SETTLE_CYC,
  parameter int LDO_SETTLE_CYC = pwsfsm_pkg::LDO_SETTLE_CYC,
  parameter int RAIL_SETTLE_CYC = pwsfsm_pkg::RAIL_SETTLE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic slow_rc_osc_i,
  input wire logic low_power_rc_clock_i,
  input wire logic [4:0] hib_wake_pin_i,
  input wire logic gpio_wake_i,
  input wire logic timer_irq_i,
  input wire logic sleep_req_i,
  input wire logic hibernate_sel_i,
  input wire logic ram_retained_i,
  input wire logic [REFRESH_W-1:0] refresh_interval_field_i,
  input wire logic supply_ok_i,
  output logic bandgap_en_o,
  output logic core_regulator_en_o,
  output logic fast_rc_osc_sel_o,
  output logic sys_reset_o,
  output logic voltage_hold_o,
  output logic power_gate_o,
  output logic woken_up_flag_o,
  output logic run_app_o,
  output logic run_boot_o,
  output logic [3:0] state_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  ////////////////////////////////////////////////////////////////////////////
  localparam int CW = pwsfsm_pkg::CNT_W;
  // settle counts at counter width
  localparam logic [CW-1:0] BG_CNT = CW'(BG_SETTLE_CYC);
  localparam logic [CW-1:0] LDO_CNT = CW'(LDO_SETTLE_CYC);
  localparam logic [CW-1:0] RAIL_CNT = CW'(RAIL_SETTLE_CYC);
  localparam logic [CW-1:0] REFR_CNT = CW'(pwsfsm_pkg::REFRESH_SETTLE_CYC);
  localparam logic [CW-1:0] BOD_CNT = CW'(pwsfsm_pkg::BOD_CHECK_CYC);

  pwsfsm_pkg::pwsfsm_state_t state_ff; // current sequencer state
  pwsfsm_pkg::pwsfsm_state_t nxt_state; // next sequencer state
  logic [CW-1:0] cnt_ff; // per-state event or cycle counter
  logic slow_prev_ff; // previous slow rc level
  logic lp_prev_ff; // previous low power rc level
  logic app_mode_ff; // 1: resume application, 0: run boot code
  logic slow_rise; // slow rc rising edge seen this cycle
  logic lp_rise; // low power rc rising edge
  logic lp_edge; // either edge of the low power rc clock
  logic cnt_evt; // the counter advances this cycle
  logic [CW-1:0] refresh_limit; // sleep length in slow rc cycles

  ////////////////////////////////////////////////////////////////////////////
  // slow clock edge detection
  ////////////////////////////////////////////////////////////////////////////
  // the slow clocks are sampled as plain synchronous inputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      // track the live level in reset, so a clock high at release is not taken as an edge
      slow_prev_ff <= slow_rc_osc_i;
      lp_prev_ff <= low_power_rc_clock_i;
    end else begin
      slow_prev_ff <= slow_rc_osc_i;
      lp_prev_ff <= low_power_rc_clock_i;
    end
  end

  assign slow_rise = slow_rc_osc_i & ~slow_prev_ff;
  assign lp_rise = low_power_rc_clock_i & ~lp_prev_ff;
  assign lp_edge = low_power_rc_clock_i ^ lp_prev_ff;

  assign refresh_limit = CW'({refresh_interval_field_i, {pwsfsm_pkg::REFRESH_LSB_SHIFT{1'b0}}});

  ////////////////////////////////////////////////////////////////////////////
  // counter event select
  ////////////////////////////////////////////////////////////////////////////
  // each state counts its own kind of event
  always_comb begin
    unique case (state_ff)
      // synchronisation and the refresh timer run on slow rc edges
      pwsfsm_pkg::ST_SYNC,
      pwsfsm_pkg::ST_SLEEP: cnt_evt = slow_rise;
      // wake controller and timer path count low power rc cycles
      pwsfsm_pkg::ST_WAKE_CTRL,
      pwsfsm_pkg::ST_TIMER_WAKE: cnt_evt = lp_rise;
      // half cycles give the 3.5 cycle switch
      pwsfsm_pkg::ST_SWITCH: cnt_evt = lp_edge;
      // no clock runs in hibernation, and run waits on no count
      pwsfsm_pkg::ST_HIBERNATE,
      pwsfsm_pkg::ST_RUN: cnt_evt = 1'b0;
      // analog settle windows count system clocks
      default: cnt_evt = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pwsfsm_pkg::ST_SYNC: begin
        if (cnt_ff >= pwsfsm_pkg::SYNC_SLOW_CYC) begin
          nxt_state = pwsfsm_pkg::ST_BG_ON;
        end
      end
      pwsfsm_pkg::ST_BG_ON: begin
        if (cnt_ff >= BG_CNT) begin
          nxt_state = pwsfsm_pkg::ST_LDO_ON;
        end
      end
      pwsfsm_pkg::ST_LDO_ON: begin
        if (cnt_ff >= LDO_CNT) begin
          nxt_state = pwsfsm_pkg::ST_RUN;
        end
      end
      // running; software asks for a low power mode
      pwsfsm_pkg::ST_RUN: begin
        if (sleep_req_i) begin
          nxt_state = hibernate_sel_i ? pwsfsm_pkg::ST_HIBERNATE : pwsfsm_pkg::ST_SLEEP;
        end
      end
      pwsfsm_pkg::ST_HIBERNATE: begin
        if (|hib_wake_pin_i) begin
          nxt_state = pwsfsm_pkg::ST_SYNC;
        end
      end
      // wake events beat the refresh timer
      pwsfsm_pkg::ST_SLEEP: begin
        if (gpio_wake_i) begin
          nxt_state = pwsfsm_pkg::ST_WAKE_CTRL;
        end else if (timer_irq_i) begin
          nxt_state = pwsfsm_pkg::ST_TIMER_WAKE;
        end else if (cnt_ff >= refresh_limit) begin
          nxt_state = pwsfsm_pkg::ST_REFRESH;
        end
      end
      pwsfsm_pkg::ST_REFRESH: begin
        if (cnt_ff >= REFR_CNT) begin
          nxt_state = pwsfsm_pkg::ST_BOD_CHECK;
        end
      end
      pwsfsm_pkg::ST_BOD_CHECK: begin
        if (cnt_ff >= BOD_CNT) begin
          if (!supply_ok_i) begin
            nxt_state = pwsfsm_pkg::ST_SYNC;
          end else if (gpio_wake_i) begin
            nxt_state = pwsfsm_pkg::ST_WAKE_CTRL;
          end else if (timer_irq_i) begin
            nxt_state = pwsfsm_pkg::ST_TIMER_WAKE;
          end else begin
            nxt_state = pwsfsm_pkg::ST_SLEEP;
          end
        end
      end
      pwsfsm_pkg::ST_WAKE_CTRL: begin
        if (cnt_ff >= pwsfsm_pkg::WAKE_CTRL_LP_CYC) begin
          nxt_state = pwsfsm_pkg::ST_RAILS;
        end
      end
      pwsfsm_pkg::ST_TIMER_WAKE: begin
        if (cnt_ff >= pwsfsm_pkg::TIMER_WAKE_LP_CYC) begin
          nxt_state = pwsfsm_pkg::ST_RAILS;
        end
      end
      pwsfsm_pkg::ST_RAILS: begin
        if (cnt_ff >= RAIL_CNT) begin
          nxt_state = pwsfsm_pkg::ST_SWITCH;
        end
      end
      pwsfsm_pkg::ST_SWITCH: begin
        if (cnt_ff >= pwsfsm_pkg::SWITCH_LP_HALF) begin
          nxt_state = pwsfsm_pkg::ST_RUN;
        end
      end
      // unused codes recover through a full power-up
      default: nxt_state = pwsfsm_pkg::ST_SYNC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and counter
  ////////////////////////////////////////////////////////////////////////////
  // reset behaves as a power-on: full sequence from synchronisation
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff <= pwsfsm_pkg::ST_SYNC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // counter restarts on every state change, so each window is measured alone
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_ff <= '0;
    end else if (nxt_state != state_ff) begin
      cnt_ff <= '0;
    end else if (cnt_evt && cnt_ff != '1) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resume target
  ////////////////////////////////////////////////////////////////////////////
  // choose application or boot
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      app_mode_ff <= 1'b0;
    end else if (nxt_state == pwsfsm_pkg::ST_SYNC) begin
      // power-up and hibernation always go through boot code
      app_mode_ff <= 1'b0;
    end else if (state_ff == pwsfsm_pkg::ST_RUN && nxt_state == pwsfsm_pkg::ST_SLEEP) begin
      // retention is latched on the way down; it cannot be re-read asleep
      app_mode_ff <= ram_retained_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power and clock controls
  ////////////////////////////////////////////////////////////////////////////
  // decoded from the next state so every output is a flop
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      bandgap_en_o <= 1'b0;
      core_regulator_en_o <= 1'b0;
      fast_rc_osc_sel_o <= 1'b0;
      sys_reset_o <= 1'b1;
      state_o <= 4'h0;
    end else begin
      bandgap_en_o <= nxt_state inside {pwsfsm_pkg::ST_BG_ON, pwsfsm_pkg::ST_LDO_ON, pwsfsm_pkg::ST_RUN,
                                        pwsfsm_pkg::ST_REFRESH, pwsfsm_pkg::ST_BOD_CHECK,
                                        pwsfsm_pkg::ST_RAILS, pwsfsm_pkg::ST_SWITCH};
      core_regulator_en_o <= nxt_state inside {pwsfsm_pkg::ST_LDO_ON, pwsfsm_pkg::ST_RUN,
                                               pwsfsm_pkg::ST_RAILS, pwsfsm_pkg::ST_SWITCH};
      fast_rc_osc_sel_o <= nxt_state inside {pwsfsm_pkg::ST_BG_ON, pwsfsm_pkg::ST_LDO_ON, pwsfsm_pkg::ST_RUN};
      sys_reset_o <= (nxt_state != pwsfsm_pkg::ST_RUN);
      state_o <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      voltage_hold_o <= 1'b0;
      power_gate_o <= 1'b0;
    end else begin
      // held voltages are released whenever the bandgap is on, and held in sleep, hibernation and the wake waits
      voltage_hold_o <= nxt_state inside {pwsfsm_pkg::ST_SLEEP, pwsfsm_pkg::ST_WAKE_CTRL,
                                          pwsfsm_pkg::ST_TIMER_WAKE, pwsfsm_pkg::ST_HIBERNATE};
      power_gate_o <= nxt_state inside {pwsfsm_pkg::ST_SLEEP, pwsfsm_pkg::ST_REFRESH,
                                        pwsfsm_pkg::ST_BOD_CHECK, pwsfsm_pkg::ST_WAKE_CTRL,
                                        pwsfsm_pkg::ST_TIMER_WAKE, pwsfsm_pkg::ST_HIBERNATE};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake status and software start
  ////////////////////////////////////////////////////////////////////////////
  // woken-up flag
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      woken_up_flag_o <= 1'b0;
    end else if (nxt_state == pwsfsm_pkg::ST_RAILS) begin
      // set on leaving the wake controller or timer wait
      woken_up_flag_o <= 1'b1;
    end else if (nxt_state inside {pwsfsm_pkg::ST_SLEEP, pwsfsm_pkg::ST_HIBERNATE, pwsfsm_pkg::ST_SYNC}) begin
      woken_up_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      run_app_o <= 1'b0;
      run_boot_o <= 1'b0;
    end else begin
      run_app_o <= (nxt_state == pwsfsm_pkg::ST_RUN) && app_mode_ff;
      run_boot_o <= (nxt_state == pwsfsm_pkg::ST_RUN) && !app_mode_ff;
    end
  end

endmodule : pwsfsm_top

// ===== verif/pwsfsm_far.sv
// rc oscillator stand-ins feeding the sequencer as sampled data
`timescale 1ns/1ps
module pwsfsm_far #(
  parameter int SLOW_HALF = 8, // clk cycles per slow rc half period
  parameter int LP_HALF = 7 // clk cycles per low power rc half period
) (
  input wire logic clk_sys_i,
  input wire logic osc_stop_i, // 1 while the device hibernates
  output logic slow_rc_osc_o,
  output logic low_power_rc_clock_o
);
  // dividers; odd lp half period keeps the two rc clocks drifting apart
  int s_ff = 0;
  int l_ff = 0;
  logic slow_ff = 1'b0; // slow rc level
  logic lp_ff = 1'b1; // low power rc level
  assign slow_rc_osc_o = slow_ff;
  assign low_power_rc_clock_o = lp_ff;
  //////////////////////////////////////////////////////////////////////
  // both oscillators run free outside hibernation; no clock runs inside it
  always @(posedge clk_sys_i) begin
    if (osc_stop_i) begin
      // stopped sources rest low and restart from a fresh phase
      s_ff <= 0;
      l_ff <= 0;
      slow_ff <= 1'b0;
      lp_ff <= 1'b0;
    end else begin
      s_ff <= (s_ff == SLOW_HALF - 1) ? 0 : s_ff + 1;
      l_ff <= (l_ff == LP_HALF - 1) ? 0 : l_ff + 1;
      if (s_ff == SLOW_HALF - 1) slow_ff <= ~slow_ff;
      if (l_ff == LP_HALF - 1) lp_ff <= ~lp_ff;
    end
  end
endmodule : pwsfsm_far

// ===== verif/pwsfsm_properties.sv
// concurrent checks on the sequencer top ports
`timescale 1ns/1ps
module pwsfsm_props #(
  parameter int REFRESH_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic slow_rc_osc_i,
  input wire logic low_power_rc_clock_i,
  input wire logic [4:0] hib_wake_pin_i,
  input wire logic gpio_wake_i,
  input wire logic timer_irq_i,
  input wire logic sleep_req_i,
  input wire logic hibernate_sel_i,
  input wire logic ram_retained_i,
  input wire logic [REFRESH_W-1:0] refresh_interval_field_i,
  input wire logic supply_ok_i,
  input wire logic bandgap_en_o,
  input wire logic core_regulator_en_o,
  input wire logic fast_rc_osc_sel_o,
  input wire logic sys_reset_o,
  input wire logic voltage_hold_o,
  input wire logic power_gate_o,
  input wire logic woken_up_flag_o,
  input wire logic run_app_o,
  input wire logic run_boot_o,
  input wire logic [3:0] state_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic slow_q_ff; // last slow rc sample
  logic lp_q_ff; // last lp rc sample
  logic [3:0] st_q_ff; // last state code
  logic [7:0] s_cnt_ff; // slow rc transitions in this state
  logic [7:0] l_cnt_ff; // lp rc transitions in this state
  //////////////////////////////////////////////////////////////////////
  // one-cycle history of the sampled clocks and the state
  always_ff @(posedge clk_sys_i) begin
    slow_q_ff <= slow_rc_osc_i;
    lp_q_ff <= low_power_rc_clock_i;
    st_q_ff <= state_o;
  end
  // transitions, not rises: ranges below allow for the phase of the clock at state entry
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_cnt_ff <= 8'h00;
      l_cnt_ff <= 8'h00;
    end else if (state_o != st_q_ff) begin
      // first edge of a new state already counts, as the design's counter does
      s_cnt_ff <= {7'h00, slow_rc_osc_i ^ slow_q_ff};
      l_cnt_ff <= {7'h00, low_power_rc_clock_i ^ lp_q_ff};
    end else begin
      s_cnt_ff <= s_cnt_ff + {7'h00, slow_rc_osc_i ^ slow_q_ff};
      l_cnt_ff <= l_cnt_ff + {7'h00, low_power_rc_clock_i ^ lp_q_ff};
    end
  end
  //////////////////////////////////////////////////////////////////////
  // one state followed by another on the next edge
  sequence leave_to(logic [3:0] a, logic [3:0] b);
    state_o == a ##1 state_o == b;
  endsequence
  a_hib_pin_wake: assert property (state_o == pwsfsm_pkg::ST_HIBERNATE && hib_wake_pin_i != 5'h00
    |=> state_o == pwsfsm_pkg::ST_SYNC) else $error("pin wake did not start sync");
  a_hib_stays_put: assert property (state_o == pwsfsm_pkg::ST_HIBERNATE && hib_wake_pin_i == 5'h00
    |=> state_o == pwsfsm_pkg::ST_HIBERNATE) else $error("hibernation left without pin");
  a_sync_slow_min: assert property (leave_to(pwsfsm_pkg::ST_SYNC, pwsfsm_pkg::ST_BG_ON)
    |-> $past(s_cnt_ff) >= 8'h05) else $error("sync shorter than three slow cycles");
  a_bg_clock_first: assert property (state_o == pwsfsm_pkg::ST_BG_ON
    |-> bandgap_en_o && fast_rc_osc_sel_o && !core_regulator_en_o && sys_reset_o) else $error("bandgap step wrong");
  a_reset_after_ldo: assert property (!sys_reset_o
    |-> core_regulator_en_o && fast_rc_osc_sel_o) else $error("reset released before regulator");
  a_wake_ctrl_len: assert property (leave_to(pwsfsm_pkg::ST_WAKE_CTRL, pwsfsm_pkg::ST_RAILS)
    |-> $past(l_cnt_ff) inside {[8'h0c:8'h0f]}) else $error("wake controller length wrong");
  a_timer_flag_len: assert property (leave_to(pwsfsm_pkg::ST_TIMER_WAKE, pwsfsm_pkg::ST_RAILS)
    |-> woken_up_flag_o && $past(l_cnt_ff) inside {[8'h0a:8'h0d]}) else $error("timer wake length wrong");
  a_switch_len: assert property (leave_to(pwsfsm_pkg::ST_SWITCH, pwsfsm_pkg::ST_RUN)
    |-> $past(l_cnt_ff) inside {[8'h06:8'h08]}) else $error("clock switch length wrong");
  a_sleep_outputs: assert property (state_o == pwsfsm_pkg::ST_SLEEP
    |-> voltage_hold_o && power_gate_o && !bandgap_en_o && !core_regulator_en_o) else $error("sleep outputs wrong");
  a_bod_outcome: assert property (state_o == pwsfsm_pkg::ST_BOD_CHECK ##1 state_o != pwsfsm_pkg::ST_BOD_CHECK
    |-> (state_o == pwsfsm_pkg::ST_SYNC) == !$past(supply_ok_i)) else $error("brown-out outcome wrong");
endmodule : pwsfsm_props
bind pwsfsm_top pwsfsm_props #(.REFRESH_W(REFRESH_W)) u_props (.*);

// ===== verif/pwsfsm_top_bench.sv
// self-checking bench for the power, wake and sleep sequencer
`timescale 1ns/1ps
module pwsfsm_top_bench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic slow_rc_osc_i, low_power_rc_clock_i;
  logic [4:0] hib_wake_pin_i = 5'h00;
  logic gpio_wake_i = 1'b0, timer_irq_i = 1'b0, sleep_req_i = 1'b0;
  logic hibernate_sel_i = 1'b0, ram_retained_i = 1'b0, supply_ok_i = 1'b1;
  logic [7:0] refresh_interval_field_i = 8'h01;
  logic bandgap_en_o, core_regulator_en_o, fast_rc_osc_sel_o, sys_reset_o;
  logic voltage_hold_o, power_gate_o, woken_up_flag_o, run_app_o, run_boot_o;
  logic [3:0] state_o;
  int err_total = 0;
  int n_compared = 0;
  logic [15:0] lf = 16'ha20b; // lfsr state, fixed seed
  logic ret; // retention picked for this pass
  int t; // cycles spent in sleep
  //////////////////////////////////////////////////////////////////////
  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  // short settle counts keep the run brief; checks use state codes and output levels, not settle lengths
  pwsfsm_top #(.BG_SETTLE_CYC(4), .LDO_SETTLE_CYC(4), .RAIL_SETTLE_CYC(4)) uut (.*);
  // rc sources stop while the device hibernates
  pwsfsm_far far (
    .clk_sys_i(clk_sys_i),
    .osc_stop_i(state_o == pwsfsm_pkg::ST_HIBERNATE),
    .slow_rc_osc_o(slow_rc_osc_i),
    .low_power_rc_clock_o(low_power_rc_clock_i)
  );
  //////////////////////////////////////////////////////////////////////
  // next lfsr value, taps 16 14 13 11
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  // sleep length in clk cycles: 64 slow cycles per count, 16 clk each
  function automatic int exp_sleep(input int iv);
    return iv * 64 * 16;
  endfunction : exp_sleep
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bounded wait for a state code
  task automatic go(input logic [3:0] s, input int max);
    int n;
    n = 0;
    while (state_o !== s && n < max) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("state", s, state_o);
  endtask : go
  // request sleep or hibernation from run
  task automatic nap(input logic r, input logic h, input logic [3:0] s);
    ram_retained_i <= r;
    hibernate_sel_i <= h;
    sleep_req_i <= 1'b1;
    go(s, 10);
    sleep_req_i <= 1'b0;
  endtask : nap
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////////////
  // watchdog well beyond the expected ~10k cycles
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    err_total++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    go(pwsfsm_pkg::ST_RUN, 300);
    chk("sys_reset", 4'h0, {3'h0, sys_reset_o});
    chk("fast_clk", 4'h1, {3'h0, fast_rc_osc_sel_o});
    chk("boot", 4'h1, {3'h0, run_boot_o});
    // gpio wake on pass 0, timer wake on pass 1, random retention
    for (int i = 0; i < 2; i++) begin
      lf = lfsr(lf);
      ret = lf[0];
      nap(ret, 1'b0, pwsfsm_pkg::ST_SLEEP);
      t = 0;
      while (state_o === pwsfsm_pkg::ST_SLEEP && t < 5000) begin
        @(posedge clk_sys_i);
        t++;
      end
      chk("refresh", pwsfsm_pkg::ST_REFRESH, state_o);
      chk("refresh_bg", 4'h1, {3'h0, bandgap_en_o});
      chk("refresh_hold", 4'h0, {3'h0, voltage_hold_o});
      chk("refresh_gate", 4'h1, {3'h0, power_gate_o});
      chk("interval", 4'h1, {3'h0, t > exp_sleep(1) - 20 && t < exp_sleep(1) + 40});
      go(pwsfsm_pkg::ST_SLEEP, 3000);
      if (i == 0) gpio_wake_i <= 1'b1;
      else timer_irq_i <= 1'b1;
      go(pwsfsm_pkg::ST_RUN, 3000);
      gpio_wake_i <= 1'b0;
      timer_irq_i <= 1'b0;
      chk("app", {3'h0, ret}, {3'h0, run_app_o});
      chk("boot", {3'h0, ~ret}, {3'h0, run_boot_o});
      chk("woken", 4'h1, {3'h0, woken_up_flag_o});
    end
    // immediate refresh with a failing supply check
    refresh_interval_field_i <= 8'h00;
    supply_ok_i <= 1'b0;
    nap(1'b1, 1'b0, pwsfsm_pkg::ST_SLEEP);
    go(pwsfsm_pkg::ST_SYNC, 3000);
    supply_ok_i <= 1'b1;
    go(pwsfsm_pkg::ST_RUN, 300);
    chk("boot", 4'h1, {3'h0, run_boot_o});
    // hibernation ignores gpio and timer, then wakes on a random pin
    nap(1'b0, 1'b1, pwsfsm_pkg::ST_HIBERNATE);
    gpio_wake_i <= 1'b1;
    timer_irq_i <= 1'b1;
    repeat (50) @(posedge clk_sys_i);
    chk("hib", pwsfsm_pkg::ST_HIBERNATE, state_o);
    gpio_wake_i <= 1'b0;
    timer_irq_i <= 1'b0;
    lf = lfsr(lf);
    hib_wake_pin_i <= (lf[4:0] == 5'h00) ? 5'h10 : lf[4:0];
    go(pwsfsm_pkg::ST_SYNC, 5);
    hib_wake_pin_i <= 5'h00;
    go(pwsfsm_pkg::ST_RUN, 300);
    chk("boot", 4'h1, {3'h0, run_boot_o});
    finish_test;
  end
endmodule : pwsfsm_top_bench
